// ==== design/ccs_consts.svh ====
// Register offsets, field positions, reset values and counts of the
// core clock select block. Included by the design and the testbench.
`ifndef CCS_CONSTS_SVH
`define CCS_CONSTS_SVH

// Byte offsets on the register bus
`define CCS_OFF_SYSCFG 8'h00
`define CCS_OFF_STATUS 8'h04
`define CCS_OFF_MASK 8'h08
`define CCS_OFF_INFO 8'h0C

// Field positions
`define CCS_BIT_MON_DIS 4
`define CCS_BIT_FAIL 0
`define CCS_BIT_SWITCHED 8

// Reset values
`define CCS_RST_SYSCFG 32'h0000_0000
`define CCS_RST_MASK 1'b0

// Strap codes that bypass the multiplier loop
`define CCS_STRAP_PRESC 3'h1
`define CCS_STRAP_DIRECT 3'h3

// Free-running loop cycles without an input transition before failure
`define CCS_MON_LIMIT 16
// Default half period of the free-running loop in system clock cycles
`define CCS_FREE_HALF_DEF 4

`endif

// ==== design/ccs_pkg.sv ====
// Types of the core clock select block.
// Assumes ccs_consts.svh is on the include path.
package ccs_pkg;
    typedef enum logic [1:0] {
        MODE_PLL,
        MODE_PRESC,
        MODE_DIRECT
    } ccs_mode_t;
endpackage

// ==== design/ccs_core_clock_select.sv ====
// Core clock source selection from reset straps, with oscillator monitor.
// Assumes one system clock, synchronous inputs and a single AHB-Lite master.
//
// Chosen here: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/10ps
`default_nettype none
`include "ccs_consts.svh"

module ccs_core_clock_select
    import ccs_pkg::*;
#(
    parameter int CW = 16,                          // Loop phase counter width
    parameter int FREE_HALF = `CCS_FREE_HALF_DEF    // Free loop half period
) (
    input wire logic clk_sys_i,                     // System clock
    input wire logic reset_i,                       // Synchronous reset
    input wire logic clock_input_pin_i,             // External clock level
    input wire logic [2:0] clock_strap_bits_i,      // Strap levels
    input wire logic hsel_i,                        // AHB select
    input wire logic [31:0] haddr_i,                // AHB address
    input wire logic [1:0] htrans_i,                // AHB transfer type
    input wire logic hwrite_i,                      // AHB write
    input wire logic [2:0] hsize_i,                 // AHB size
    input wire logic [31:0] hwdata_i,               // AHB write data
    input wire logic hready_i,                      // AHB ready in
    output logic hreadyout_o,                       // AHB ready out
    output logic hresp_o,                           // AHB response
    output logic [31:0] hrdata_o,                   // AHB read data
    output logic core_clk_o,                        // Core clock
    output logic loop_enable_o,                     // Loop powered
    output logic clock_fail_irq_request_o,          // Sticky failure flag
    output logic irq_o                              // Masked interrupt
);
    if (CW < 8 || CW > 30) begin
        $error("CW out of range");
    end
    if (FREE_HALF < 1 || FREE_HALF > 255) begin
        $error("FREE_HALF out of range");
    end

    localparam int SWITCH_MAX = 4 * FREE_HALF + 4;
    localparam logic [31:0] RST_SYSCFG = `CCS_RST_SYSCFG;

    function automatic ccs_mode_t ccs_mode(input logic [2:0] code);
        return (code == `CCS_STRAP_PRESC) ? MODE_PRESC
            : ((code == `CCS_STRAP_DIRECT) ? MODE_DIRECT : MODE_PLL);
    endfunction

    // Factor numerator and denominator
    function automatic logic [2:0] ccs_num(input logic [2:0] code);
        unique case (code)
            3'h7: return 3'h4;
            3'h6: return 3'h3;
            3'h5: return 3'h2;
            3'h4: return 3'h5;
            3'h2: return 3'h3;
            3'h0: return 3'h5;
            default: return 3'h1;
        endcase
    endfunction

    function automatic logic [2:0] ccs_den(input logic [2:0] code);
        return (code == 3'h2 || code == 3'h0) ? 3'h2 : 3'h1;
    endfunction

    logic [2:0] strap_q;
    ccs_mode_t mode;
    logic pin_q, trans, disable_q, mask_q, stat_q, fail_q, sel_free_q, core_clk_q;
    logic free_clk_q, free_on, free_rise, mon_active, fail_evt, presc_clk_q, pll_clk_q;
    logic resync, src_clk, addr_ok, rd_stat, wr_pend_q;
    logic [7:0] free_div_q;
    logic [7:0] wr_addr_q;
    logic [3:0] mon_cnt_q;
    logic [2:0] tcnt_q;
    logic [CW-1:0] win_q, win_len_q, acc_q, step;
    logic [CW:0] acc_sum;

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            strap_q <= clock_strap_bits_i;
        end
    end

    assign mode = ccs_mode(strap_q);

    // No reset value, so a pin idling high gives no false edge after reset
    always_ff @(posedge clk_sys_i) begin
        pin_q <= clock_input_pin_i;
    end

    assign trans = clock_input_pin_i ^ pin_q;

    // Multiplier loop: 2*num half periods spread over 2*den input transitions
    assign step = CW'({ccs_num(strap_q), 1'b0});
    assign acc_sum = {1'b0, acc_q} + {1'b0, step};
    assign resync = trans && (tcnt_q == 3'(2 * ccs_den(strap_q) - 1));

    always_ff @(posedge clk_sys_i) begin
        if (reset_i || mode != MODE_PLL) begin
            tcnt_q <= 3'h0;
            win_q <= '0;
            win_len_q <= '1;
            acc_q <= '0;
            pll_clk_q <= 1'b0;
        end else if (resync) begin
            tcnt_q <= 3'h0;
            win_len_q <= win_q + CW'(1);
            win_q <= '0;
            acc_q <= '0;
            pll_clk_q <= 1'b1;
        end else begin
            if (trans) begin
                tcnt_q <= tcnt_q + 3'h1;
            end
            if (win_q != '1) begin
                win_q <= win_q + CW'(1);
            end
            if (acc_sum >= {1'b0, win_len_q}) begin
                acc_q <= CW'(acc_sum - {1'b0, win_len_q});
                pll_clk_q <= ~pll_clk_q;
            end else begin
                acc_q <= acc_sum[CW-1:0];
            end
        end
    end

    // Prescaler toggles on each rising input edge
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            presc_clk_q <= 1'b0;
        end else if (clock_input_pin_i && !pin_q) begin
            presc_clk_q <= ~presc_clk_q;
        end
    end

    always_comb begin
        unique case (mode)
            MODE_PRESC: src_clk = presc_clk_q;
            MODE_DIRECT: src_clk = pin_q;
            MODE_PLL: src_clk = pll_clk_q;
            default: src_clk = 1'b0;
        endcase
    end

    // Free-running loop, powered while the monitor is on or after a switch
    assign mon_active = (mode != MODE_PLL) && !disable_q;
    assign free_on = mon_active || sel_free_q;
    assign free_rise = free_on && !free_clk_q && (free_div_q == 8'(FREE_HALF - 1));

    always_ff @(posedge clk_sys_i) begin
        if (reset_i || !free_on) begin
            free_div_q <= 8'h00;
            free_clk_q <= 1'b0;
        end else if (free_div_q == 8'(FREE_HALF - 1)) begin
            free_div_q <= 8'h00;
            free_clk_q <= ~free_clk_q;
        end else begin
            free_div_q <= free_div_q + 8'h01;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (reset_i || !mon_active || trans) begin
            mon_cnt_q <= 4'h0;
        end else if (free_rise && mon_cnt_q != 4'hF) begin
            mon_cnt_q <= mon_cnt_q + 4'h1;
        end
    end

    assign fail_evt = mon_active && free_rise && !trans && !fail_q
        && (mon_cnt_q == 4'(`CCS_MON_LIMIT - 1));

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            fail_q <= 1'b0;
        end else if (fail_evt) begin
            fail_q <= 1'b1;
        end
    end

    // Hand over as a free low phase starts; the dead source may be stuck high
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            sel_free_q <= 1'b0;
        end else if (fail_q && !free_clk_q && free_div_q == 8'h00) begin
            sel_free_q <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            core_clk_q <= 1'b0;
        end else begin
            core_clk_q <= sel_free_q ? free_clk_q : src_clk;
        end
    end

    // AHB-Lite slave, zero wait states
    assign addr_ok = hsel_i && htrans_i[1] && hready_i;
    assign rd_stat = addr_ok && !hwrite_i && (haddr_i[7:0] == `CCS_OFF_STATUS)
        && (haddr_i[31:8] == 24'h00_0000);

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
        end else begin
            wr_pend_q <= addr_ok && hwrite_i && (haddr_i[31:8] == 24'h00_0000);
            wr_addr_q <= haddr_i[7:0];
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            disable_q <= RST_SYSCFG[`CCS_BIT_MON_DIS];
        end else if (wr_pend_q && wr_addr_q == `CCS_OFF_SYSCFG) begin
            disable_q <= hwdata_i[`CCS_BIT_MON_DIS];
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            mask_q <= `CCS_RST_MASK;
        end else if (wr_pend_q && wr_addr_q == `CCS_OFF_MASK) begin
            mask_q <= hwdata_i[`CCS_BIT_FAIL];
        end
    end

    // Set wins over the read clear
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            stat_q <= 1'b0;
        end else if (fail_evt) begin
            stat_q <= 1'b1;
        end else if (rd_stat) begin
            stat_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            hrdata_o <= 32'h0000_0000;
        end else if (addr_ok && !hwrite_i && haddr_i[31:8] == 24'h00_0000) begin
            hrdata_o <= 32'h0000_0000;
            unique case (haddr_i[7:0])
                `CCS_OFF_SYSCFG: hrdata_o[`CCS_BIT_MON_DIS] <= disable_q;
                `CCS_OFF_STATUS: hrdata_o[`CCS_BIT_FAIL] <= stat_q;
                `CCS_OFF_MASK: hrdata_o[`CCS_BIT_FAIL] <= mask_q;
                `CCS_OFF_INFO: begin
                    hrdata_o[2:0] <= strap_q;
                    hrdata_o[`CCS_BIT_SWITCHED] <= sel_free_q;
                end
                default: hrdata_o <= 32'h0000_0000;
            endcase
        end else begin
            hrdata_o <= 32'h0000_0000;
        end
    end

    assign hreadyout_o = 1'b1;
    assign hresp_o = 1'b0;
    assign core_clk_o = core_clk_q;
    assign loop_enable_o = (mode == MODE_PLL) || free_on;
    assign clock_fail_irq_request_o = stat_q;
    assign irq_o = stat_q && mask_q;

    property p_strap_hold;
        @(posedge clk_sys_i) disable iff (reset_i)
        !$past(reset_i) |-> $stable(strap_q);
    endproperty
    a_strap_hold: assert property (p_strap_hold) else $error("strap changed");

    property p_presc_toggle;
        @(posedge clk_sys_i) disable iff (reset_i)
        (mode == MODE_PRESC && clock_input_pin_i && !pin_q)
            |=> (presc_clk_q != $past(presc_clk_q));
    endproperty
    a_presc_toggle: assert property (p_presc_toggle) else $error("no toggle");

    property p_direct_follow;
        @(posedge clk_sys_i) disable iff (reset_i)
        (mode == MODE_DIRECT && !sel_free_q) |=> (core_clk_q == $past(pin_q));
    endproperty
    a_direct_follow: assert property (p_direct_follow) else $error("direct off");

    property p_resync;
        @(posedge clk_sys_i) disable iff (reset_i)
        (mode == MODE_PLL && resync) |=> (pll_clk_q && acc_q == '0);
    endproperty
    a_resync: assert property (p_resync) else $error("no resync");

    property p_mon_idle;
        @(posedge clk_sys_i) disable iff (reset_i)
        (mode == MODE_PLL) |-> (mon_cnt_q == 4'h0 && !fail_q);
    endproperty
    a_mon_idle: assert property (p_mon_idle) else $error("monitor in loop mode");

    property p_dis_reset;
        @(posedge clk_sys_i) disable iff (reset_i)
        $fell(reset_i) |-> !disable_q;
    endproperty
    a_dis_reset: assert property (p_dis_reset) else $error("disable set");

    property p_mon_count;
        @(posedge clk_sys_i) disable iff (reset_i)
        (mon_active && free_rise && !trans && mon_cnt_q != 4'hF)
            |=> (mon_cnt_q == $past(mon_cnt_q) + 4'h1);
    endproperty
    a_mon_count: assert property (p_mon_count) else $error("no count");

    property p_mon_clear;
        @(posedge clk_sys_i) disable iff (reset_i)
        trans |=> (mon_cnt_q == 4'h0);
    endproperty
    a_mon_clear: assert property (p_mon_clear) else $error("no clear");

    property p_fail_limit;
        @(posedge clk_sys_i) disable iff (reset_i)
        $rose(fail_q) |-> ($past(mon_cnt_q) == 4'hF && !$past(trans));
    endproperty
    a_fail_limit: assert property (p_fail_limit) else $error("early fail");

    property p_switch;
        @(posedge clk_sys_i) disable iff (reset_i)
        $rose(fail_q) |-> ##[1:SWITCH_MAX] sel_free_q;
    endproperty
    a_switch: assert property (p_switch) else $error("no switch");

    property p_stay;
        @(posedge clk_sys_i) disable iff (reset_i)
        sel_free_q |=> (sel_free_q && core_clk_q == $past(free_clk_q));
    endproperty
    a_stay: assert property (p_stay) else $error("left free source");

    property p_loop_off;
        @(posedge clk_sys_i) disable iff (reset_i)
        (disable_q && !sel_free_q && mode != MODE_PLL) |-> !loop_enable_o;
    endproperty
    a_loop_off: assert property (p_loop_off) else $error("loop on");

    property p_flag_set;
        @(posedge clk_sys_i) disable iff (reset_i)
        fail_evt |=> clock_fail_irq_request_o;
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("flag lost");
endmodule
`default_nettype wire

// ==== sim/ccs_osc_model.sv ====
// Behavioural external clock oscillator that drives the clock input pin.
// Assumes the system clock paces it; when stopped the pin holds its level.
`timescale 1ns/10ps
`default_nettype none
module ccs_osc_model (
    input wire logic clk_sys_i,      // System clock
    input wire logic run_i,          // Oscillator running
    input wire logic [7:0] hi_i,     // High time in cycles
    input wire logic [7:0] lo_i,     // Low time in cycles
    output logic pin_o               // Clock pin level
);
    logic [7:0] cnt_q;
    initial begin
        pin_o = 1'b0;
        cnt_q = 8'h00;
    end
    // A dead oscillator freezes the pin, as a failed crystal would
    always @(posedge clk_sys_i) begin
        if (run_i && cnt_q + 8'h01 >= (pin_o ? hi_i : lo_i)) begin
            pin_o <= ~pin_o;
            cnt_q <= 8'h00;
        end else if (run_i) begin
            cnt_q <= cnt_q + 8'h01;
        end
    end
endmodule
`default_nettype wire

// ==== sim/core_clock_select_osc_monitor_test.sv ====
// Testbench of the core clock select block: registers, clock paths, monitor.
// Assumes the design files and the oscillator model compile before it.
`timescale 1ns/10ps
`default_nettype none
`include "ccs_consts.svh"
module core_clock_select_osc_monitor_test;
    localparam int FH = 2;
    typedef struct packed {
        logic [31:0] a;
        logic w;
        logic [31:0] d;
        logic [31:0] e;
    } ccs_row_t;
    logic clk_sys_i, reset_i, hsel, hwrite, osc_run;
    logic [1:0] htrans;
    logic [2:0] strap;
    logic [7:0] osc_hi, osc_lo;
    logic [31:0] haddr, hwdata, rd;
    wire logic pin, hready, hresp, core, loop_en, fail, irq;
    wire logic [31:0] hrdata;
    int error_cnt, samples_checked, cyc, h, l, n, r, i;
    logic prev;
    ccs_row_t rows [8];
    logic [2:0] pc [6];
    int pf [6];

    ccs_core_clock_select #(.FREE_HALF(FH)) dut (.clk_sys_i(clk_sys_i),
        .reset_i(reset_i), .clock_input_pin_i(pin), .clock_strap_bits_i(strap),
        .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
        .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready),
        .hreadyout_o(hready), .hresp_o(hresp), .hrdata_o(hrdata), .core_clk_o(core),
        .loop_enable_o(loop_en), .clock_fail_irq_request_o(fail), .irq_o(irq));
    ccs_osc_model osc (.clk_sys_i(clk_sys_i), .run_i(osc_run), .hi_i(osc_hi),
        .lo_i(osc_lo), .pin_o(pin));

    initial begin
        clk_sys_i = 1'b0;
        forever #5 clk_sys_i = ~clk_sys_i;
    end

    task final_report;
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    always @(posedge clk_sys_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            final_report();
        end
    end

    task chk32(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task chk1(input logic got, input logic exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task step;
        @(posedge clk_sys_i);
        #1;
    endtask

    // One single transfer: address phase, then data phase, each held for hready
    task ahb(input logic [31:0] a, input logic w, input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge clk_sys_i); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk_sys_i); while (hready !== 1'b1);
        rd = hrdata;
        #1;
    endtask

    // Straps are flipped at release so only the value held in reset counts
    task rst(input logic [2:0] s);
        strap <= s;
        reset_i <= 1'b1;
        repeat (6) @(posedge clk_sys_i);
        reset_i <= 1'b0;
        strap <= ~s;
        @(posedge clk_sys_i);
    endtask

    task meas;
        h = 0;
        l = 0;
        n = 0;
        while (core !== 1'b0 && n < 300) begin step(); n++; end
        while (core !== 1'b1 && n < 300) begin step(); n++; end
        while (core === 1'b1 && n < 300) begin step(); n++; h++; end
        while (core === 1'b0 && n < 300) begin step(); n++; l++; end
    endtask

    task done(input string s);
        $display("test %s finished", s);
    endtask

    initial begin
        reset_i = 1'b1;
        strap = 3'h3;
        {hsel, hwrite, htrans, haddr, hwdata} = '0;
        {osc_run, osc_hi, osc_lo} = {1'b1, 8'h03, 8'h05};
        {error_cnt, samples_checked, cyc} = '0;
        rows = '{'{`CCS_OFF_SYSCFG, 1'b0, 32'h0, `CCS_RST_SYSCFG},
                 '{`CCS_OFF_MASK, 1'b0, 32'h0, 32'h0},
                 '{`CCS_OFF_STATUS, 1'b0, 32'h0, 32'h0},
                 '{`CCS_OFF_INFO, 1'b0, 32'h0, 32'h3},
                 '{32'h10, 1'b0, 32'h0, 32'h0},
                 '{`CCS_OFF_INFO, 1'b1, 32'hFFFFFFFF, 32'h3},
                 '{32'h10, 1'b1, 32'hFFFFFFFF, 32'h0},
                 '{`CCS_OFF_MASK, 1'b1, 32'hFFFFFFFF, 32'h1}};
        pc = '{3'h7, 3'h6, 3'h5, 3'h4, 3'h2, 3'h0};
        pf = '{8, 6, 4, 10, 3, 5};
        rst(3'h3);
        for (i = 0; i < 8; i++) begin
            if (rows[i].w) ahb(rows[i].a, 1'b1, rows[i].d);
            ahb(rows[i].a, 1'b0, 32'h0);
            chk32(rd, rows[i].e);
        end
        done("registers");
        meas();
        chk32(h, 3);
        chk32(l, 5);
        chk1(loop_en, 1'b1);
        done("direct");
        osc_run <= 1'b0;
        n = 0;
        while (fail !== 1'b1 && n < 200) begin step(); n++; end
        chk1(n > 40 && n < 80, 1'b1);
        chk1(irq, 1'b1);
        osc_run <= 1'b1;
        repeat (100) step();
        chk1(fail, 1'b1);
        meas();
        chk32(h, FH);
        chk32(l, FH);
        ahb(`CCS_OFF_INFO, 1'b0, 32'h0);
        chk32(rd, 32'h103);
        ahb(`CCS_OFF_MASK, 1'b1, 32'h0);
        chk1(irq, 1'b0);
        ahb(`CCS_OFF_MASK, 1'b1, 32'h1);
        chk1(irq, 1'b1);
        ahb(`CCS_OFF_STATUS, 1'b0, 32'h0);
        chk32(rd, 32'h1);
        chk1(fail, 1'b0);
        chk1(irq, 1'b0);
        done("failure");
        rst(3'h3);
        ahb(`CCS_OFF_INFO, 1'b0, 32'h0);
        chk32(rd, 32'h3);
        chk32(hrdata, 32'h0);
        chk1(hresp, 1'b0);
        done("reset");
        ahb(`CCS_OFF_SYSCFG, 1'b1, 32'h10);
        ahb(`CCS_OFF_SYSCFG, 1'b0, 32'h0);
        chk32(rd, 32'h10);
        chk1(loop_en, 1'b0);
        osc_run <= 1'b0;
        repeat (200) step();
        chk1(fail, 1'b0);
        osc_run <= 1'b1;
        meas();
        chk32(h, 3);
        chk32(l, 5);
        done("monitor off");
        rst(3'h1);
        meas();
        chk32(h, 8);
        chk32(l, 8);
        done("prescaler");
        osc_hi <= 8'h14;
        osc_lo <= 8'h14;
        for (i = 0; i < 6; i++) begin
            rst(pc[i]);
            repeat (400) step();
            r = 0;
            prev = core;
            repeat (320) begin
                step();
                if (core === 1'b1 && prev === 1'b0) r++;
                prev = core;
            end
            chk1(r >= pf[i] * 4 - 2 && r <= pf[i] * 4 + 2, 1'b1);
            chk1(loop_en, 1'b1);
            osc_run <= 1'b0;
            repeat (150) step();
            chk1(fail, 1'b0);
            osc_run <= 1'b1;
        end
        done("multiplier");
        final_report();
    end
endmodule
`default_nettype wire
